// ### hdl/ckd_regs.svh
`ifndef CKD_REGS_SVH
`define CKD_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CKD_SYNC_CTRL 8'h00
`define CKD_POST_DIV 8'h04
`define CKD_MUX_SEL 8'h08
`define CKD_MARGIN_EN 8'h0C
`define CKD_MUTE_EN 8'h10
`define CKD_MUTE_LVL 8'h14
`define CKD_ODIV_BASE 8'h18
`define CKD_OCTRL_BASE 8'h30
`define CKD_STATUS 8'h50
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CKD_SC_REQ_BIT 0
`define CKD_SC_EN1_BIT 1
`define CKD_SC_EN2_BIT 2
`define CKD_SC_SOFT_BIT 3
`define CKD_SYNC_CTRL_RST 4'h1
`define CKD_OCTRL_RST 7'h00
`define CKD_ODIV_RST 8'h00
`define CKD_POST_RST 3'h0
// ----------------------------------------
// timing counts
// ----------------------------------------
`define CKD_SYNC_SLOW_EDGES 2'h2
`define CKD_SYNC_VCO_CYCLES 2'h2
`define CKD_MARGIN_MIN_RATIO 8'h07
`endif

// ### hdl/ckd_pkg.sv
package ckd_pkg;
  typedef enum logic [2:0] {
    CKD_FMT_OFF = 3'h0,
    CKD_FMT_LVPECL = 3'h1,
    CKD_FMT_LVDS = 3'h2,
    CKD_FMT_CML = 3'h3,
    CKD_FMT_HCSL = 3'h4,
    CKD_FMT_LVCMOS = 3'h5
  } ckd_fmt_e;
  typedef enum logic [1:0] {
    CKD_SYNC_RUN = 2'h0,
    CKD_SYNC_ARM = 2'h1,
    CKD_SYNC_VCO = 2'h2,
    CKD_SYNC_HOLD = 2'h3
  } ckd_sync_e;
  typedef enum logic [1:0] {
    CKD_SRC_PRI = 2'h0,
    CKD_SRC_SEC = 2'h1,
    CKD_SRC_PLL1 = 2'h2,
    CKD_SRC_PLL2 = 2'h3
  } ckd_src_e;
endpackage

// ### hdl/ckd_div.sv
`timescale 1ns/1ps
`default_nettype none
module ckd_div
  import ckd_pkg::*;
(
  input wire logic i_clk, // block clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_tick, // one pulse per source rising edge
  input wire logic i_src, // source level, used for divide by one
  input wire logic [7:0] i_ratio, // divide value minus one
  input wire logic i_live, // reload only at period end
  input wire logic i_hold, // hold counter in reset
  output logic o_clk, // divided clock level
  output logic o_rise, // rising edge pulse
  output logic o_fall // falling edge pulse
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] ratio;
    logic clk;
    logic rise;
    logic fall;
  } ckd_div_s;
  ckd_div_s st, next_st;
  logic [7:0] high_cnt;

  // ----------------------------------------
  // counter with period-boundary reload
  // ----------------------------------------
  // a live change waits for the wrap so no period is ever cut short
  always_comb begin
    next_st = st;
    high_cnt = 8'((9'(st.ratio) + 9'h002) >> 1);
    if (i_hold) begin
      next_st.cnt = 8'h00;
      next_st.ratio = i_ratio;
      next_st.clk = 1'b0;
    end else if (!i_live && i_ratio != st.ratio) begin
      next_st.cnt = 8'h00; // plain restart, may runt
      next_st.ratio = i_ratio;
    end else if (st.ratio == 8'h00) begin
      next_st.clk = i_src; // divide by one passes the source
      next_st.ratio = i_ratio;
    end else if (i_tick) begin
      if (st.cnt == st.ratio) begin
        next_st.cnt = 8'h00;
        next_st.ratio = i_ratio;
      end else begin
        next_st.cnt = st.cnt + 8'h01;
      end
      next_st.clk = (next_st.cnt < high_cnt);
    end
    next_st.rise = next_st.clk & ~st.clk;
    next_st.fall = ~next_st.clk & st.clk;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_clk = st.clk;
  assign o_rise = st.rise;
  assign o_fall = st.fall;
endmodule // ckd_div
`default_nettype wire

// ### hdl/ckd_outdrv.sv
`timescale 1ns/1ps
`default_nettype none
module ckd_outdrv
  import ckd_pkg::*;
(
  input wire logic i_clk, // block clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_oclk, // divided output clock level
  input wire logic [6:0] i_ctrl, // output control field
  input wire logic i_mute_req, // source invalid and muting allowed
  input wire logic i_mute_lvl, // static level while muted
  input wire logic i_sync_off, // sync hold tri-states the driver
  output logic o_p, // p pin level
  output logic o_n, // n pin level
  output logic o_p_oe, // p pin drive enable
  output logic o_n_oe, // n pin drive enable
  output logic o_term, // on-chip termination on
  output logic o_active // driver enabled
);
  typedef struct packed {
    logic en;
    logic mute;
    logic p;
    logic n;
    logic p_oe;
    logic n_oe;
    logic term;
  } ckd_drv_s;
  ckd_drv_s st, next_st;
  ckd_fmt_e fmt;
  logic want;
  logic diff;

  // ----------------------------------------
  // driver state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    fmt = ckd_fmt_e'(i_ctrl[2:0]);
    diff = (fmt == CKD_FMT_LVPECL) || (fmt == CKD_FMT_LVDS) || (fmt == CKD_FMT_CML);
    want = (i_ctrl[5:0] != 6'h00) && (fmt <= CKD_FMT_LVCMOS) && (fmt != CKD_FMT_OFF);
    // changes land only while the clock is low, so no runt escapes
    if (!i_oclk) begin
      next_st.en = want;
      next_st.mute = i_mute_req;
    end
    next_st.term = diff || (fmt == CKD_FMT_HCSL && i_ctrl[6]);
    if (!st.en || i_sync_off) begin
      next_st.p_oe = 1'b0;
      next_st.n_oe = 1'b0;
      next_st.p = 1'b0;
      next_st.n = 1'b0;
    end else if (fmt == CKD_FMT_LVCMOS) begin
      // bit3 drives p, bit4 drives n, bit5 makes n complementary
      next_st.p_oe = i_ctrl[3];
      next_st.n_oe = i_ctrl[4];
      next_st.p = st.mute ? i_mute_lvl : i_oclk;
      next_st.n = (st.mute ? i_mute_lvl : i_oclk) ^ i_ctrl[5];
    end else begin
      next_st.p_oe = 1'b1;
      next_st.n_oe = 1'b1;
      next_st.p = st.mute ? i_mute_lvl : i_oclk;
      next_st.n = st.mute ? ~i_mute_lvl : ~i_oclk;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_p = st.p;
  assign o_n = st.n;
  assign o_p_oe = st.p_oe;
  assign o_n_oe = st.n_oe;
  assign o_term = st.term;
  assign o_active = st.en;
endmodule // ckd_outdrv
`default_nettype wire

// ### hdl/ckd_top.sv
// Notes on behaviour
// - each pll post divider divides its vco by 2 to 8 from a 3-bit field
// - outputs 0/1 and 2/3 each pick pll1 or pll2 with one bit
// - outputs 4 to 7 each pick primary, secondary, pll1 or pll2 with two bits
// - a selected reference is taken before the doubler, so undoubled
// - six output dividers, 1 to 256; 0/1 and 2/3 share, 4 to 7 own
// - margining per channel, only when that channel divides by more than 8
// - with margining, new divide value applies glitch free at period end
// - each output has its own format select among five signalling kinds
// - each output may auto-mute when its reference or pll is invalid
// - muted static level is chosen per output
// - control field low six bits all zero turns that output off
// - lvds, cml and lvpecl formats switch on the on-chip termination
// - lvcmos p pin in-phase or off, n pin complementary, in-phase or off
// - active-low sync from the pin in soft mode or a register bit
// - per-pll sync enables pick which outputs tri-state and hold dividers
// - sync low tri-states affected drivers and resets dividers
// - reset after two slowest-clock falling edges plus two vco cycles
// - sync latency varies by at most one vco cycle
// - output enable and disable are aligned to the output clock
`timescale 1ns/1ps
`default_nettype none
`include "ckd_regs.svh"
module ckd_top
  import ckd_pkg::*;
(
  input wire logic i_clk, // 100 MHz block clock, also the vco rate
  input wire logic i_rstn, // async reset, active low
  input wire logic [7:0] i_paddr, // apb address
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error on unmapped address
  input wire logic [1:0] i_vco_tick, // one pulse per vco cycle, per pll
  input wire logic [1:0] i_pll_lock, // pll lock pins
  input wire logic i_pri_ref, // primary reference, pre-doubler
  input wire logic i_sec_ref, // secondary reference, pre-doubler
  input wire logic i_pri_valid, // primary reference present
  input wire logic i_sec_valid, // secondary reference present
  input wire logic i_general_pin_zero, // sync request pin, active low
  output logic [7:0] o_out_p, // output p levels
  output logic [7:0] o_out_n, // output n levels
  output logic [7:0] o_out_p_oe, // output p drive enables
  output logic [7:0] o_out_n_oe, // output n drive enables
  output logic [7:0] o_out_term // output termination enables
);
  typedef struct packed {
    logic [6:0] pin_s1; // first sync stage, read by pin_s2 only
    logic [6:0] pin_s2;
    logic [1:0] ref_d;
    logic [3:0] sync_ctrl;
    logic [5:0] post_div;
    logic [9:0] mux_sel;
    logic [5:0] margin_en;
    logic [7:0] mute_en;
    logic [7:0] mute_lvl;
    logic [47:0] odiv;
    logic [55:0] octrl;
    ckd_sync_e sync_st;
    logic [1:0] sync_cnt;
    logic sync_hold;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ckd_top_s;
  ckd_top_s st, next_st;

  logic [1:0] post_clk;
  logic [1:0] post_rise;
  logic [5:0] od_clk;
  logic [5:0] od_fall;
  logic [5:0] od_hold;
  logic [5:0] src_lvl;
  logic [5:0] src_tick;
  logic [5:0] src_pll2;
  logic [5:0] src_pll;
  logic [5:0] src_bad;
  logic [7:0] out_active;
  logic [1:0] pll_hold;
  logic sync_req_low;
  logic slow_fall;
  logic [7:0] slow_ratio;
  logic [7:0] wr_idx;
  logic addr_ok;
  logic [31:0] rd_val;
  logic [1:0] lock_s;
  logic pri_s;
  logic sec_s;
  logic pri_ok;
  logic sec_ok;
  logic [1:0] ref_rise;

  // ----------------------------------------
  // synchronised pin views
  // ----------------------------------------
  assign lock_s = st.pin_s2[1:0];
  assign pri_s = st.pin_s2[2];
  assign sec_s = st.pin_s2[3];
  assign pri_ok = st.pin_s2[4];
  assign sec_ok = st.pin_s2[5];
  // edges are taken from the second stage onward, never the first
  assign ref_rise = {sec_s, pri_s} & ~st.ref_d;

  // ----------------------------------------
  // pll post dividers
  // ----------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_post
      logic [2:0] fld;
      logic [7:0] pratio;
      assign fld = st.post_div[gp*3 +: 3];
      // field 0..6 means divide 2..8, code 7 is clamped to 8
      assign pratio = (fld == 3'h7) ? 8'h07 : {5'h00, fld} + 8'h01;
      ckd_div u_post (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_tick(i_vco_tick[gp]),
        .i_src(1'b0),
        .i_ratio(pratio),
        .i_live(1'b0),
        .i_hold(pll_hold[gp]),
        .o_clk(post_clk[gp]),
        .o_rise(post_rise[gp]),
        .o_fall()
      );
    end
  endgenerate

  // ----------------------------------------
  // source muxes and output dividers
  // ----------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < 6; gc++) begin : g_chan
      logic [7:0] ratio;
      always_comb begin
        src_pll2[gc] = 1'b0;
        src_pll[gc] = 1'b1;
        src_lvl[gc] = 1'b0;
        src_tick[gc] = 1'b0;
        src_bad[gc] = 1'b0;
        if (gc < 2) begin
          src_pll2[gc] = st.mux_sel[gc];
          src_lvl[gc] = post_clk[src_pll2[gc]];
          src_tick[gc] = post_rise[src_pll2[gc]];
          src_bad[gc] = ~lock_s[src_pll2[gc]];
        end else begin
          case (ckd_src_e'(st.mux_sel[((gc < 2) ? 2 : 2*gc-2) +: 2]))
            CKD_SRC_PRI: begin
              src_pll[gc] = 1'b0;
              src_lvl[gc] = pri_s;
              src_tick[gc] = ref_rise[0];
              src_bad[gc] = ~pri_ok;
            end
            CKD_SRC_SEC: begin
              src_pll[gc] = 1'b0;
              src_lvl[gc] = sec_s;
              src_tick[gc] = ref_rise[1];
              src_bad[gc] = ~sec_ok;
            end
            CKD_SRC_PLL1: begin
              src_lvl[gc] = post_clk[0];
              src_tick[gc] = post_rise[0];
              src_bad[gc] = ~lock_s[0];
            end
            default: begin
              src_pll2[gc] = 1'b1;
              src_lvl[gc] = post_clk[1];
              src_tick[gc] = post_rise[1];
              src_bad[gc] = ~lock_s[1];
            end
          endcase
        end
      end
      assign ratio = st.odiv[gc*8 +: 8];
      // only pll-fed channels follow the sync hold of their pll
      assign od_hold[gc] = src_pll[gc] & pll_hold[src_pll2[gc]];
      ckd_div u_odiv (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_tick(src_tick[gc]),
        .i_src(src_lvl[gc]),
        .i_ratio(ratio),
        .i_live(st.margin_en[gc] && ratio > `CKD_MARGIN_MIN_RATIO),
        .i_hold(od_hold[gc]),
        .o_clk(od_clk[gc]),
        .o_rise(),
        .o_fall(od_fall[gc])
      );
    end
  endgenerate

  // ----------------------------------------
  // output drivers, 0/1 on channel 0, 2/3 on channel 1
  // ----------------------------------------
  genvar go;
  generate
    for (go = 0; go < 8; go++) begin : g_out
      localparam int CH = (go < 2) ? 0 : ((go < 4) ? 1 : go - 2);
      ckd_outdrv u_drv (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_oclk(od_clk[CH]),
        .i_ctrl(st.octrl[go*7 +: 7]),
        .i_mute_req(src_bad[CH] & st.mute_en[go]),
        .i_mute_lvl(st.mute_lvl[go]),
        .i_sync_off(od_hold[CH]),
        .o_p(o_out_p[go]),
        .o_n(o_out_n[go]),
        .o_p_oe(o_out_p_oe[go]),
        .o_n_oe(o_out_n_oe[go]),
        .o_term(o_out_term[go]),
        .o_active(out_active[go])
      );
    end
  endgenerate

  // ----------------------------------------
  // sync request and slowest clock pick
  // ----------------------------------------
  // pin counts only in soft pin mode; either source low requests sync
  assign sync_req_low = ~st.sync_ctrl[`CKD_SC_REQ_BIT] |
                        (st.sync_ctrl[`CKD_SC_SOFT_BIT] & ~st.pin_s2[6]);
  assign pll_hold = {2{st.sync_hold}} &
                    {st.sync_ctrl[`CKD_SC_EN2_BIT], st.sync_ctrl[`CKD_SC_EN1_BIT]};
  always_comb begin
    slow_ratio = 8'h00;
    slow_fall = od_fall[0];
    for (int i = 0; i < 6; i++) begin
      if (st.odiv[i*8 +: 8] > slow_ratio) begin
        slow_ratio = st.odiv[i*8 +: 8];
        slow_fall = od_fall[i];
      end
    end
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  always_comb begin
    wr_idx = 8'h00;
    addr_ok = 1'b1;
    rd_val = 32'h0000_0000;
    if (i_paddr[1:0] != 2'h0) begin
      addr_ok = 1'b0;
    end else if (i_paddr == `CKD_SYNC_CTRL) begin
      rd_val = {28'h0000000, st.sync_ctrl};
    end else if (i_paddr == `CKD_POST_DIV) begin
      rd_val = {25'h0000000, st.post_div[5:3], 1'b0, st.post_div[2:0]};
    end else if (i_paddr == `CKD_MUX_SEL) begin
      rd_val = {22'h000000, st.mux_sel};
    end else if (i_paddr == `CKD_MARGIN_EN) begin
      rd_val = {26'h0000000, st.margin_en};
    end else if (i_paddr == `CKD_MUTE_EN) begin
      rd_val = {24'h000000, st.mute_en};
    end else if (i_paddr == `CKD_MUTE_LVL) begin
      rd_val = {24'h000000, st.mute_lvl};
    end else if (i_paddr >= `CKD_ODIV_BASE && i_paddr < `CKD_OCTRL_BASE) begin
      wr_idx = (i_paddr - `CKD_ODIV_BASE) >> 2;
      rd_val = {24'h000000, st.odiv[wr_idx*8 +: 8]};
    end else if (i_paddr >= `CKD_OCTRL_BASE && i_paddr < `CKD_STATUS) begin
      wr_idx = (i_paddr - `CKD_OCTRL_BASE) >> 2;
      rd_val = {25'h0000000, st.octrl[wr_idx*7 +: 7]};
    end else if (i_paddr == `CKD_STATUS) begin
      rd_val = {19'h00000, sec_ok, pri_ok, lock_s, st.sync_hold, out_active};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.pin_s1 = {i_general_pin_zero, i_sec_valid, i_pri_valid, i_sec_ref, i_pri_ref,
                      i_pll_lock};
    next_st.pin_s2 = st.pin_s1;
    next_st.ref_d = {sec_s, pri_s};
    // setup phase loads the answer, access phase shows it with ready
    next_st.pready = i_psel & ~i_penable;
    next_st.pslverr = i_psel & ~i_penable & ~addr_ok;
    if (i_psel && !i_penable) begin
      next_st.prdata = i_pwrite ? 32'h0000_0000 : rd_val;
    end
    if (i_psel && i_penable && st.pready && i_pwrite && addr_ok) begin
      if (i_paddr == `CKD_SYNC_CTRL) begin
        next_st.sync_ctrl = i_pwdata[3:0];
      end else if (i_paddr == `CKD_POST_DIV) begin
        next_st.post_div = {i_pwdata[6:4], i_pwdata[2:0]};
      end else if (i_paddr == `CKD_MUX_SEL) begin
        next_st.mux_sel = i_pwdata[9:0];
      end else if (i_paddr == `CKD_MARGIN_EN) begin
        next_st.margin_en = i_pwdata[5:0];
      end else if (i_paddr == `CKD_MUTE_EN) begin
        next_st.mute_en = i_pwdata[7:0];
      end else if (i_paddr == `CKD_MUTE_LVL) begin
        next_st.mute_lvl = i_pwdata[7:0];
      end else if (i_paddr >= `CKD_ODIV_BASE && i_paddr < `CKD_OCTRL_BASE) begin
        next_st.odiv[wr_idx*8 +: 8] = i_pwdata[7:0];
      end else if (i_paddr >= `CKD_OCTRL_BASE && i_paddr < `CKD_STATUS) begin
        next_st.octrl[wr_idx*7 +: 7] = i_pwdata[6:0];
      end
    end
    // the slow clock stops once held, so release runs on vco cycles only
    case (st.sync_st)
      CKD_SYNC_RUN: begin
        next_st.sync_cnt = 2'h0;
        if (sync_req_low) begin
          next_st.sync_st = CKD_SYNC_ARM;
        end
      end
      CKD_SYNC_ARM: begin
        if (!sync_req_low) begin
          next_st.sync_st = CKD_SYNC_RUN; // too short, see requester hold time
        end else if (slow_fall) begin
          if (st.sync_cnt == `CKD_SYNC_SLOW_EDGES - 2'h1) begin
            next_st.sync_cnt = 2'h0;
            next_st.sync_st = CKD_SYNC_VCO;
          end else begin
            next_st.sync_cnt = st.sync_cnt + 2'h1;
          end
        end
      end
      CKD_SYNC_VCO: begin
        // fixed cycle count keeps the latency deterministic
        if (st.sync_cnt == `CKD_SYNC_VCO_CYCLES - 2'h1) begin
          next_st.sync_hold = 1'b1;
          next_st.sync_st = CKD_SYNC_HOLD;
        end else begin
          next_st.sync_cnt = st.sync_cnt + 2'h1;
        end
      end
      CKD_SYNC_HOLD: begin
        if (!sync_req_low) begin
          next_st.sync_hold = 1'b0; // one edge frees every held divider
          next_st.sync_st = CKD_SYNC_RUN;
        end
      end
      default: begin
        next_st.sync_st = CKD_SYNC_RUN;
        next_st.sync_hold = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
      st.sync_ctrl <= `CKD_SYNC_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_prdata = st.prdata;
  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;
endmodule // ckd_top
`default_nettype wire

// ### bench/ckd_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ckd_mon (
  input wire logic i_clk, // clock
  input wire logic i_rstn, // reset, active low
  input wire logic [7:0] i_paddr, // apb address
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [31:0] o_prdata, // read data
  input wire logic o_pready, // ready
  input wire logic o_pslverr, // error
  input wire logic [7:0] o_out_p_oe, // p drive enables
  input wire logic [7:0] o_out_term // terminations
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // setup phase of a transfer
  wire setup = i_psel & ~i_penable;
  a_ready_setup: assert property (setup |=> o_pready) else $error("no ready");
  a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("long ready");
  a_ready_access: assert property (o_pready |-> $past(setup))
    else $error("stray ready");
  a_err_ready: assert property (o_pslverr |-> o_pready) else $error("stray error");
  a_misalign_err: assert property (setup && i_paddr[1:0] != 2'h0 |=> o_pslverr)
    else $error("misaligned accepted");
  a_bad_read: assert property (setup && !i_pwrite && i_paddr > 8'h50 |=>
    o_pslverr && o_prdata == 32'h0) else $error("unmapped read");
  a_ctrl_ok: assert property (setup && i_paddr[7:4] == 4'h3 && i_paddr[1:0] == 2'h0
    |=> !o_pslverr) else $error("control refused");
  // read data may only move when a new transfer starts
  a_data_hold: assert property (!setup |=> $stable(o_prdata))
    else $error("read data moved");
  c_err: cover property (o_pslverr);
  c_on: cover property ($rose(o_out_p_oe[0]));
  c_off: cover property ($fell(o_out_p_oe[0]));
  c_term: cover property (o_out_term[0]);
endmodule // ckd_mon
bind ckd_top ckd_mon u_ckd_mon (.i_clk(i_clk), .i_rstn(i_rstn), .i_paddr(i_paddr),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_out_p_oe(o_out_p_oe),
  .o_out_term(o_out_term));
`default_nettype wire

// ### bench/ckd_far.sv
`timescale 1ns/1ps
`default_nettype none
module ckd_far (
  input wire logic i_clk, // clock
  input wire logic i_rstn, // reset, active low
  input wire logic i_drop, // bench asks pll1 to unlock
  output logic [1:0] o_tick, // vco pulses
  output logic [1:0] o_lock, // pll locks
  output logic o_pri, // primary reference
  output logic o_sec, // secondary reference
  output logic o_pri_ok, // primary present
  output logic o_sec_ok // secondary present
);
  logic [3:0] cnt;
  // references kept well below half the block rate so the 2ff sync sees every edge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end
  assign o_pri = cnt[2]; // period 8
  assign o_sec = cnt[3]; // period 16
  assign o_tick = 2'h3; // vco at block rate
  assign o_lock = {1'b1, ~i_drop};
  assign o_pri_ok = 1'b1;
  assign o_sec_ok = 1'b1;
endmodule // ckd_far
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic gpin = 1'b1, drop = 1'b0, pready, pslverr, pri, sec, pri_ok, sec_ok, e;
  logic [7:0] paddr = 8'h00, out_p, out_n, poe, noe, term;
  logic [31:0] pwdata = 32'h0, prdata, rdv, p;
  logic [1:0] tick, lock;
  logic [31:0] pd [3] = '{32'h0, 32'h1, 32'h60};
  logic [31:0] od [3] = '{32'h3, 32'h0, 32'h1};
  logic [31:0] pe [3] = '{32'h8, 32'h3, 32'h10};
  logic [7:0] fc [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h44, 8'h0D, 8'h15, 8'h00, 8'h40};
  logic [2:0] fx [9] = '{3'h7, 3'h7, 3'h7, 3'h3, 3'h7, 3'h2, 3'h1, 3'h0, 3'h0};
  int mismatches = 0, samples_checked = 0, cyc = 0;
  always #5 clk = ~clk;
  ckd_top u_ckd_top (.i_clk(clk), .i_rstn(rstn), .i_paddr(paddr), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_vco_tick(tick), .i_pll_lock(lock),
    .i_pri_ref(pri), .i_sec_ref(sec), .i_pri_valid(pri_ok), .i_sec_valid(sec_ok),
    .i_general_pin_zero(gpin), .o_out_p(out_p), .o_out_n(out_n), .o_out_p_oe(poe),
    .o_out_n_oe(noe), .o_out_term(term));
  ckd_far u_ckd_far (.i_clk(clk), .i_rstn(rstn), .i_drop(drop), .o_tick(tick),
    .o_lock(lock), .o_pri(pri), .o_sec(sec), .o_pri_ok(pri_ok), .o_sec_ok(sec_ok));
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; the wait for ready is cut short only by the run ceiling
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
    input logic xe);
    apb(1'b0, a, 32'h0);
    check(rdv & m, x);
    check({31'h0, e}, {31'h0, xe});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // cycles between two rising edges of an output, zero means stuck
  task automatic per(input int k, output logic [31:0] n);
    int r;
    int t;
    logic l;
    r = 0;
    t = 0;
    n = 0;
    l = out_p[k];
    while (r < 2 && t < 400) begin
      @(posedge clk);
      t++;
      if (r == 1) n++;
      if (out_p[k] && !l) r++;
      l = out_p[k];
    end
  endtask
  // ceiling far above the under two thousand cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 32'hFF, 32'h1, 1'b0);
    rd(8'h30, 32'hFF, 32'h0, 1'b0);
    rd(8'h54, 32'hFFFFFFFF, 32'h0, 1'b1);
    rd(8'h02, 32'hFFFFFFFF, 32'h0, 1'b1);
    // post divider, pll mux and output divider chain on output 0
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h04, pd[i]);
      apb(1'b1, 8'h08, {31'h0, i == 2});
      apb(1'b1, 8'h18, od[i]);
      apb(1'b1, 8'h30, 32'h2);
      per(0, p);
      per(0, p);
      check(p, pe[i]);
    end
    // formats, termination and pin enables, ending with two off codes
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, 8'h30, {24'h0, fc[i]});
      wt(40);
      check({29'h0, term[0], poe[0], noe[0]}, 32'(fx[i]));
    end
    apb(1'b1, 8'h30, 32'h1D);
    wt(40);
    check({31'h0, out_n[0] ^ out_p[0]}, 32'h0);
    apb(1'b1, 8'h30, 32'h3D);
    wt(40);
    check({31'h0, out_n[0] ^ out_p[0]}, 32'h1);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h18, 32'h9);
    apb(1'b1, 8'h30, 32'h2);
    per(0, p);
    per(0, p);
    check(p, 32'h14);
    apb(1'b1, 8'h18, 32'hB);
    per(0, p);
    check({31'h0, p == 32'h14 || p == 32'h18}, 32'h1);
    per(0, p);
    check(p, 32'h18);
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b1, 8'h10, 32'h1);
    drop <= 1'b1;
    wt(60);
    check({31'h0, out_p[0]}, 32'h1);
    wt(13);
    check({31'h0, out_p[0]}, 32'h1);
    drop <= 1'b0;
    per(0, p);
    per(0, p);
    check(p, 32'h18);
    apb(1'b1, 8'h40, 32'hD);
    per(4, p);
    per(4, p);
    check(p, 32'h8);
    apb(1'b1, 8'h08, 32'h4);
    per(4, p);
    per(4, p);
    check(p, 32'h10);
    apb(1'b1, 8'h08, 32'hC);
    per(4, p);
    per(4, p);
    check(p, 32'h2);
    wt(40);
    apb(1'b1, 8'h00, 32'h2);
    wt(3);
    check({31'h0, poe[0]}, 32'h1);
    wt(80);
    check({30'h0, poe[0], poe[4]}, 32'h1);
    rd(8'h50, 32'h100, 32'h100, 1'b0);
    apb(1'b1, 8'h00, 32'h3);
    wt(60);
    check({30'h0, poe[0], poe[4]}, 32'h3);
    apb(1'b1, 8'h00, 32'hB);
    gpin <= 1'b0;
    wt(80);
    check({31'h0, poe[0]}, 32'h0);
    gpin <= 1'b1;
    wt(60);
    check({31'h0, poe[0]}, 32'h1);
    test_done();
  end
endmodule // testbench
`default_nettype wire
